//--- design/saf_addr_seq.sv
/*
  48-bit station address store with separate read and write word
  pointers behind one 16-bit port. assumes the caller gates port strobes
  while the flash loader owns the store.
*/
`timescale 1ns/10ps
module saf_addr_seq (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // port strobes
  input wire logic port_we,
  input wire logic port_re,
  input wire logic [15:0] port_wdata,
  // flash loader
  input wire logic load_we,
  input wire saf_pkg::saf_word_t load_word,
  input wire logic [15:0] load_data,
  input wire logic load_done,
  // results
  output logic [15:0] rd_word,
  output logic [47:0] station_q
);

  // ==========================================================
  // pointers
  saf_pkg::saf_word_t wr_ptr_q;
  saf_pkg::saf_word_t wr_ptr_d;
  saf_pkg::saf_word_t rd_ptr_q;
  saf_pkg::saf_word_t rd_ptr_d;

  always_comb begin
    wr_ptr_d = wr_ptr_q;
    if (load_done || port_re) begin
      wr_ptr_d = saf_pkg::SAF_WORD_LO;
    end else if (port_we) begin
      wr_ptr_d = saf_pkg::saf_next_word(wr_ptr_q);
    end
  end

  always_comb begin
    rd_ptr_d = rd_ptr_q;
    if (load_done || port_we) begin
      rd_ptr_d = saf_pkg::SAF_WORD_LO;
    end else if (port_re) begin
      rd_ptr_d = saf_pkg::saf_next_word(rd_ptr_q);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= saf_pkg::SAF_WORD_LO;
      rd_ptr_q <= saf_pkg::SAF_WORD_LO;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
    end
  end

  // ==========================================================
  // store: no reset on purpose, only a power-on load refills it
  always_ff @(posedge clk_sys) begin
    if (load_we) begin
      station_q <= saf_pkg::saf_put_word(station_q, load_word, load_data);
    end else if (port_we) begin
      station_q <= saf_pkg::saf_put_word(station_q, wr_ptr_q, port_wdata);
    end
  end

  assign rd_word = saf_pkg::saf_get_word(station_q, rd_ptr_q);

endmodule : saf_addr_seq

//--- design/saf_flash_load.sv
/*
  power-on loader: copies three words of the station address out of the
  flash information block. assumes a flash read port that answers each
  one-cycle request with one rvalid pulse, in order.
*/
`timescale 1ns/10ps
module saf_flash_load #(
  parameter logic [15:0] FLASH_BASE = saf_pkg::SAF_FLASH_INFO_BASE
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic por_flag,
  // flash read port
  output logic flash_rd,
  output logic [15:0] flash_addr,
  input wire logic [15:0] flash_rdata,
  input wire logic flash_rvalid,
  // store side
  output logic load_we,
  output saf_pkg::saf_word_t load_word,
  output logic [15:0] load_data,
  output logic load_done,
  output logic busy
);

  // ==========================================================
  // sequencer
  saf_pkg::saf_ld_t st_q;
  saf_pkg::saf_word_t word_q;

  // por_flag is only looked at after reset release, never under reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= saf_pkg::SAF_LD_ARM;
      word_q <= saf_pkg::SAF_WORD_LO;
      busy <= 1'b1;
      flash_rd <= 1'b0;
      flash_addr <= FLASH_BASE;
      load_we <= 1'b0;
      load_word <= saf_pkg::SAF_WORD_LO;
      load_data <= saf_pkg::SAF_LOCAL_RESET;
      load_done <= 1'b0;
    end else begin
      flash_rd <= 1'b0;
      load_we <= 1'b0;
      load_done <= 1'b0;
      case (st_q)
        saf_pkg::SAF_LD_ARM: begin
          word_q <= saf_pkg::SAF_WORD_LO;
          if (por_flag) begin
            st_q <= saf_pkg::SAF_LD_REQ;
          end else begin
            st_q <= saf_pkg::SAF_LD_IDLE;
            busy <= 1'b0;
          end
        end
        saf_pkg::SAF_LD_REQ: begin
          flash_rd <= 1'b1;
          flash_addr <= FLASH_BASE + 16'(word_q);
          st_q <= saf_pkg::SAF_LD_WAIT;
        end
        saf_pkg::SAF_LD_WAIT: begin
          if (flash_rvalid) begin
            load_we <= 1'b1;
            load_word <= word_q;
            load_data <= flash_rdata;
            word_q <= saf_pkg::saf_next_word(word_q);
            if (word_q == saf_pkg::SAF_WORD_HI) begin
              load_done <= 1'b1;
              busy <= 1'b0;
              st_q <= saf_pkg::SAF_LD_IDLE;
            end else begin
              st_q <= saf_pkg::SAF_LD_REQ;
            end
          end
        end
        saf_pkg::SAF_LD_IDLE: begin
          busy <= 1'b0;
        end
        default: begin
          st_q <= saf_pkg::SAF_LD_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

endmodule : saf_flash_load

//--- design/saf_pkg.sv
/*
  constants, types and helpers shared by the station address filter
  register block. assumes a 16-bit special-register bus on the mcu side.
*/
package saf_pkg;

  // ==========================================================
  // widths
  localparam int SAF_DATA_W = 16;
  localparam int SAF_STATION_W = 48;
  localparam int SAF_FLASH_AW = 16;

  // ==========================================================
  // register map: module index and register index
  localparam logic [7:0] SAF_MODULE_IDX = 8'h02;
  localparam logic [7:0] SAF_IDX_STATION = 8'h14;
  localparam logic [7:0] SAF_IDX_LOCAL = 8'h15;
  localparam logic [7:0] SAF_IDX_MCAST = 8'h16;

  // ==========================================================
  // reset values
  localparam logic [15:0] SAF_LOCAL_RESET = 16'h0000;
  localparam logic [15:0] SAF_MCAST_RESET = 16'h003f;
  localparam logic [15:0] SAF_UNMAPPED_READ = 16'h0000;

  // base of the station address in the flash information block
  localparam logic [15:0] SAF_FLASH_INFO_BASE = 16'h0000;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    SAF_WORD_LO,
    SAF_WORD_MID,
    SAF_WORD_HI
  } saf_word_t;

  typedef enum logic [1:0] {
    SAF_LD_ARM,
    SAF_LD_REQ,
    SAF_LD_WAIT,
    SAF_LD_IDLE
  } saf_ld_t;

  // ==========================================================
  // helpers
  function automatic saf_word_t saf_next_word(input saf_word_t w);
    case (w)
      SAF_WORD_LO: saf_next_word = SAF_WORD_MID;
      SAF_WORD_MID: saf_next_word = SAF_WORD_HI;
      default: saf_next_word = SAF_WORD_LO;
    endcase
  endfunction : saf_next_word

  function automatic logic [15:0] saf_get_word(input logic [47:0] v, input saf_word_t w);
    case (w)
      SAF_WORD_LO: saf_get_word = v[15:0];
      SAF_WORD_MID: saf_get_word = v[31:16];
      default: saf_get_word = v[47:32];
    endcase
  endfunction : saf_get_word

  function automatic logic [47:0] saf_put_word(input logic [47:0] v, input saf_word_t w,
                                               input logic [15:0] d);
    logic [47:0] r;
    r = v;
    case (w)
      SAF_WORD_LO: r[15:0] = d;
      SAF_WORD_MID: r[31:16] = d;
      default: r[47:32] = d;
    endcase
    saf_put_word = r;
  endfunction : saf_put_word

endpackage : saf_pkg

//--- design/saf_regs.sv
/*
  station address filter registers: station address port, local network
  address and multicast mask on the mcu special-register bus, plus the
  filter-facing copies. assumes strobes are one-cycle pulses synchronous
  to clk_sys and that rst covers every reset cause.
*/
`timescale 1ns/10ps
module saf_regs #(
  parameter logic [15:0] FLASH_BASE = saf_pkg::SAF_FLASH_INFO_BASE
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic por_flag,
  // special-register bus
  input wire logic [7:0] sfr_mod,
  input wire logic [7:0] sfr_idx,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [15:0] sfr_wdata,
  output logic [15:0] sfr_rdata,
  // flash information block
  output logic flash_rd,
  output logic [15:0] flash_addr,
  input wire logic [15:0] flash_rdata,
  input wire logic flash_rvalid,
  // receive filter
  input wire logic promisc_mode,
  output logic filt_en,
  output logic [47:0] filt_station_addr,
  output logic [15:0] filt_local_addr,
  output logic [15:0] filt_mcast_mask,
  output logic station_load_busy
);

  // ==========================================================
  // decode
  logic mod_hit;
  logic hit_station;
  logic hit_local;
  logic hit_mcast;
  logic port_we;
  logic port_re;
  logic load_busy;

  assign mod_hit = (sfr_mod == saf_pkg::SAF_MODULE_IDX);
  assign hit_station = mod_hit && (sfr_idx == saf_pkg::SAF_IDX_STATION);
  assign hit_local = mod_hit && (sfr_idx == saf_pkg::SAF_IDX_LOCAL);
  assign hit_mcast = mod_hit && (sfr_idx == saf_pkg::SAF_IDX_MCAST);

  // the loader owns the store while it runs, so bus strobes cannot
  // tear the freshly loaded address or move its pointers
  assign port_we = hit_station && sfr_wr && !load_busy;
  assign port_re = hit_station && sfr_rd && !load_busy;

  // ==========================================================
  // power-on loader
  logic load_we;
  saf_pkg::saf_word_t load_word;
  logic [15:0] load_data;
  logic load_done;

  saf_flash_load #(
    .FLASH_BASE(FLASH_BASE)
  ) u_load (
    .clk_sys(clk_sys),
    .rst(rst),
    .por_flag(por_flag),
    .flash_rd(flash_rd),
    .flash_addr(flash_addr),
    .flash_rdata(flash_rdata),
    .flash_rvalid(flash_rvalid),
    .load_we(load_we),
    .load_word(load_word),
    .load_data(load_data),
    .load_done(load_done),
    .busy(load_busy)
  );

  // ==========================================================
  // station address store
  logic [15:0] station_rd_word;

  saf_addr_seq u_seq (
    .clk_sys(clk_sys),
    .rst(rst),
    .port_we(port_we),
    .port_re(port_re),
    .port_wdata(sfr_wdata),
    .load_we(load_we),
    .load_word(load_word),
    .load_data(load_data),
    .load_done(load_done),
    .rd_word(station_rd_word),
    .station_q(filt_station_addr)
  );

  // ==========================================================
  // local network address
  logic [15:0] local_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      local_q <= saf_pkg::SAF_LOCAL_RESET;
    end else if (hit_local && sfr_wr) begin
      local_q <= sfr_wdata;
    end
  end

  // ==========================================================
  // multicast mask
  logic [15:0] mcast_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mcast_q <= saf_pkg::SAF_MCAST_RESET;
    end else if (hit_mcast && sfr_wr) begin
      mcast_q <= sfr_wdata;
    end
  end

  assign filt_local_addr = local_q;
  assign filt_mcast_mask = mcast_q;

  // ==========================================================
  // read data
  logic [15:0] rdata_d;

  always_comb begin
    rdata_d = saf_pkg::SAF_UNMAPPED_READ;
    if (hit_station) begin
      // during the load the port reads as zero and moves nothing
      rdata_d = load_busy ? saf_pkg::SAF_UNMAPPED_READ : station_rd_word;
    end else if (hit_local) begin
      rdata_d = local_q;
    end else if (hit_mcast) begin
      rdata_d = mcast_q;
    end
  end

  // holds the last answer between reads
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sfr_rdata <= saf_pkg::SAF_UNMAPPED_READ;
    end else if (sfr_rd && mod_hit) begin
      sfr_rdata <= rdata_d;
    end
  end

  // ==========================================================
  // filter enable and status
  // filtering is off until the power-on load has settled the address
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      filt_en <= 1'b0;
      station_load_busy <= 1'b1;
    end else begin
      filt_en <= !promisc_mode && !load_busy;
      station_load_busy <= load_busy;
    end
  end

endmodule : saf_regs

//--- verification/saf_regs_sva.sv
/*
  checker for saf_regs: port-level properties of the station address port,
  local address, multicast mask and filter enable. assumes one clock domain.
*/
`timescale 1ns/10ps
module saf_regs_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register bus
  input wire logic [7:0] sfr_mod,
  input wire logic [7:0] sfr_idx,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [15:0] sfr_wdata,
  input wire logic [15:0] sfr_rdata,
  // flash and filter
  input wire logic flash_rd,
  input wire logic promisc_mode,
  input wire logic filt_en,
  input wire logic [47:0] filt_station_addr,
  input wire logic [15:0] filt_local_addr,
  input wire logic [15:0] filt_mcast_mask,
  input wire logic station_load_busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic hit;
  logic st_wr;
  logic st_rd;
  // single-strobe accesses only: both strobes together reset both pointers to the low word
  assign hit = sfr_mod == 8'h02 && !(sfr_wr && sfr_rd);
  assign st_wr = hit && sfr_wr && sfr_idx == 8'h14 && !station_load_busy;
  assign st_rd = hit && sfr_rd && sfr_idx == 8'h14 && !station_load_busy;
  // ==========================================================
  // station address port
  fill_order_a: assert property (st_rd ##1 st_wr [*3] |=>
    filt_station_addr == {$past(sfr_wdata), $past(sfr_wdata, 2), $past(sfr_wdata, 3)})
    else $error("station address fill order wrong");
  read_low_a: assert property (st_wr ##1 st_rd |=>
    sfr_rdata == $past(filt_station_addr[15:0])) else $error("read after write not low");
  read_mid_a: assert property (st_wr ##1 st_rd [*2] |=>
    sfr_rdata == $past(filt_station_addr[31:16])) else $error("second read not middle");
  read_wrap_a: assert property (st_wr ##1 st_rd [*4] |=>
    sfr_rdata == $past(filt_station_addr[15:0])) else $error("fourth read not low");
  load_busy_a: assert property (flash_rd |-> station_load_busy)
    else $error("flash read outside load");
  // ==========================================================
  // local address, multicast mask, filter enable
  // two reset edges: at time zero the flops only settle on the first clock under reset
  reset_val_a: assert property (disable iff (1'b0) rst ##1 rst |->
    filt_local_addr == 16'h0000 && filt_mcast_mask == 16'h003f) else $error("reset values");
  local_wr_a: assert property (hit && sfr_wr && sfr_idx == 8'h15 |=>
    filt_local_addr == $past(sfr_wdata)) else $error("local write lost");
  mcast_rd_a: assert property (hit && sfr_rd && sfr_idx == 8'h16 |=>
    sfr_rdata == $past(filt_mcast_mask)) else $error("mcast read wrong");
  promisc_off_a: assert property (promisc_mode |=> !filt_en)
    else $error("filter on in promiscuous mode");
  filt_on_a: assert property (!promisc_mode ##1 !station_load_busy |-> filt_en)
    else $error("filter off outside promiscuous mode");
  cover property (st_wr ##1 st_rd [*4]);
  cover property (flash_rd);
  cover property ($fell(station_load_busy));
endmodule : saf_regs_chk

bind saf_regs saf_regs_chk u_chk (.clk_sys(clk_sys), .rst(rst), .sfr_mod(sfr_mod),
  .sfr_idx(sfr_idx), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata), .flash_rd(flash_rd), .promisc_mode(promisc_mode),
  .filt_en(filt_en), .filt_station_addr(filt_station_addr),
  .filt_local_addr(filt_local_addr), .filt_mcast_mask(filt_mcast_mask),
  .station_load_busy(station_load_busy));

//--- verification/tb_station_address_filter_regs.sv
/*
  self-checking bench for saf_regs. the bench answers flash reads itself,
  one cycle after each request; inputs change 1 ns after the rising edge.
*/
`timescale 1ns/10ps
module tb_station_address_filter_regs;
  localparam logic [15:0] BASE = 16'h0100;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic por_flag = 1'b1;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic flash_rvalid = 1'b0;
  logic promisc_mode = 1'b0;
  logic [7:0] sfr_idx = 8'h00;
  logic [15:0] sfr_wdata = 16'h0000;
  logic [15:0] flash_rdata = 16'h0000;
  logic [15:0] sfr_rdata, flash_addr, filt_local_addr, filt_mcast_mask;
  logic flash_rd, filt_en, station_load_busy;
  logic [47:0] filt_station_addr, st_save;
  int n_mismatch = 0;
  int n_compared = 0;
  always #10 clk_sys = ~clk_sys;
  saf_regs #(.FLASH_BASE(BASE)) DUT (.clk_sys(clk_sys), .rst(rst), .por_flag(por_flag),
    .sfr_mod(8'h02), .sfr_idx(sfr_idx), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .flash_rd(flash_rd),
    .flash_addr(flash_addr), .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid),
    .promisc_mode(promisc_mode), .filt_en(filt_en), .filt_station_addr(filt_station_addr),
    .filt_local_addr(filt_local_addr), .filt_mcast_mask(filt_mcast_mask),
    .station_load_busy(station_load_busy));
  function automatic logic [15:0] fdat(input logic [15:0] a);
    fdat = a ^ 16'h5a3c;
  endfunction : fdat
  // idle flash data toggles so a late sample cannot match by luck
  always @(posedge clk_sys) begin
    flash_rvalid <= #1 flash_rd;
    flash_rdata <= #1 flash_rd ? fdat(flash_addr) : ~flash_rdata;
  end
  // ==========================================================
  // bus and check helpers
  task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // strobe stays up on return so accesses can run back to back
  task automatic acc(input logic w, input logic [7:0] idx, input logic [15:0] d);
    sfr_wr = w;
    sfr_rd = ~w;
    sfr_idx = idx;
    sfr_wdata = d;
    @(posedge clk_sys);
    #1;
  endtask : acc
  task automatic idle(input int n);
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  // ==========================================================
  // scenarios
  task automatic t_por;
    int k;
    for (k = 0; k < 60 && station_load_busy !== 1'b0; k++) @(posedge clk_sys);
    #1;
    chk("station load", {fdat(BASE + 16'h0002), fdat(BASE + 16'h0001), fdat(BASE)},
      filt_station_addr);
    chk("local reset", 48'h0, filt_local_addr);
    acc(1'b0, 8'h16, 16'h0000);
    chk("mcast reset", 48'h3f, sfr_rdata);
    $display("test por done");
  endtask : t_por
  task automatic t_station;
    acc(1'b0, 8'h14, 16'h0000);
    chk("first read", fdat(BASE), sfr_rdata);
    acc(1'b1, 8'h14, 16'h1111);
    acc(1'b1, 8'h14, 16'h2222);
    acc(1'b1, 8'h14, 16'h3333);
    chk("station fill", 48'h3333_2222_1111, filt_station_addr);
    acc(1'b0, 8'h14, 16'h0000);
    chk("read lo", 48'h1111, sfr_rdata);
    acc(1'b0, 8'h14, 16'h0000);
    chk("read mid", 48'h2222, sfr_rdata);
    acc(1'b0, 8'h14, 16'h0000);
    chk("read hi", 48'h3333, sfr_rdata);
    acc(1'b0, 8'h14, 16'h0000);
    chk("read wrap", 48'h1111, sfr_rdata);
    idle(1);
    $display("test station done");
  endtask : t_station
  task automatic t_ptrs;
    acc(1'b1, 8'h14, 16'h4444);
    acc(1'b1, 8'h14, 16'h5555);
    acc(1'b0, 8'h14, 16'h0000);
    chk("read after write", 48'h4444, sfr_rdata);
    acc(1'b1, 8'h14, 16'h6666);
    chk("write after read", 48'h3333_5555_6666, filt_station_addr);
    acc(1'b1, 8'h14, 16'h7777);
    acc(1'b1, 8'h14, 16'h8888);
    acc(1'b1, 8'h14, 16'h9999);
    chk("write wrap", 48'h8888_7777_9999, filt_station_addr);
    idle(1);
    $display("test pointers done");
  endtask : t_ptrs
  task automatic t_rw;
    acc(1'b1, 8'h15, 16'hbeef);
    acc(1'b1, 8'h16, 16'h1234);
    acc(1'b0, 8'h15, 16'h0000);
    chk("local read", 48'hbeef, sfr_rdata);
    acc(1'b0, 8'h16, 16'h0000);
    chk("mcast read", 48'h1234, sfr_rdata);
    acc(1'b0, 8'h17, 16'h0000);
    chk("unmapped read", 48'h0, sfr_rdata);
    chk("local filter", 48'hbeef, filt_local_addr);
    chk("mcast filter", 48'h1234, filt_mcast_mask);
    promisc_mode = 1'b1;
    idle(2);
    chk("filter promisc", 48'h0, filt_en);
    promisc_mode = 1'b0;
    idle(2);
    chk("filter on", 48'h1, filt_en);
    $display("test rw done");
  endtask : t_rw
  task automatic t_rst2;
    st_save = filt_station_addr;
    rst = 1'b1;
    por_flag = 1'b0;
    idle(2);
    rst = 1'b0;
    idle(3);
    chk("local second reset", 48'h0, filt_local_addr);
    chk("mcast second reset", 48'h3f, filt_mcast_mask);
    chk("station kept", st_save, filt_station_addr);
    chk("no load", 48'h0, station_load_busy);
    $display("test second reset done");
  endtask : t_rst2
  initial begin
    #(20 * 3000);
    n_mismatch++;
    $display("watchdog expired");
    close_out();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_por();
    t_station();
    t_ptrs();
    t_rw();
    t_rst2();
    close_out();
  end
endmodule : tb_station_address_filter_regs
